// ### src/dff_pkg.sv
// constants for the diagnostic fault-flag unit
package dff_pkg;
   localparam logic [7:0]  ADDR_FLAG_WORD     = 8'ha3;
   localparam int          FLAG_COUNT         = 13;
   localparam int          BIT_ANALOG         = 0;
   localparam int          BIT_CLAMP          = 1;
   localparam int          BIT_TEMP           = 2;
   localparam int          BIT_SAT            = 3;
   localparam int          BIT_LOGIC          = 4;
   localparam int          BIT_RADIUS         = 5;
   localparam int          BIT_POWER_ON       = 6;
   localparam int          BIT_EE_SINGLE      = 7;
   localparam int          BIT_UNDERVOLT      = 8;
   localparam int          BIT_OVERVOLT       = 9;
   localparam int          BIT_EE_MULTI       = 10;
   localparam int          BIT_SHADOW_PAR     = 11;
   localparam int          BIT_OSC            = 12;
   localparam logic [31:0] FLAG_WORD_RESET    = 32'h0000_0040;
   localparam int          CLK_PERIOD_NS      = 100;
   localparam int          TEMP_INTERVAL_US   = 1500;
   localparam int          TEMP_CHECK_CYCLES  = TEMP_INTERVAL_US * 1000 / CLK_PERIOD_NS;
   localparam int          FILTER_MAX_UPDATES = 16;
   localparam logic [3:0]  OSC_START_UPDATES  = 4'ha;
   localparam int          OSC_TOL_PCT        = 20;
   localparam int          OSC_NOM_CYCLES     = 100;
   localparam int          ANGLE_W            = 16;
   typedef enum logic [2:0] {
      DFF_OSC_IDLE    = 3'b001,
      DFF_OSC_WAIT    = 3'b010,
      DFF_OSC_MEASURE = 3'b100
   } dff_osc_state_t;
endpackage

// ### src/dff_fault_flags.sv
// diagnostic fault-flag collector with masks, fault filters and read/report clearing
`timescale 1ns/1ps
//
// Operation
// [RULE_01] flags packed in read-only word, upper bits zero
// [RULE_02] non-critical flags clear on read/report after recovery
// [RULE_03] analog check failure sets flag, fault state
// [RULE_04] analog check mask suppresses its flag
// [RULE_05] clamp reached sets flag, clears after return
// [RULE_06] clamp mask keeps clamp flag low
// [RULE_07] clamp evaluated per update, filtered up to 16
// [RULE_08] temperature out of range sets flag, fault
// [RULE_09] temperature checked every 1.5 ms
// [RULE_10] temperature mask suppresses its flag
// [RULE_11] saturation is OR of four masked sub-flags
// [RULE_12] global saturation mask suppresses whole flag
// [RULE_13] filter sub-flag unless its mask set
// [RULE_14] channel sub-flag unless its mask set
// [RULE_15] correction sub-flag from three enabled checks; wrap
// [RULE_16] linearization sub-flag unless its mask set
// [RULE_17] saturation flag clears on read/report after recovery
// [RULE_18] saturation evaluated per update, filtered up to 16
// [RULE_19] oscillator deviation over 20% latches critical flag
// [RULE_20] oscillator check every 10 updates, maskable
// [RULE_21] power-on flag clears only after first update
// [RULE_22] eeprom multi-bit flag unmaskable, reset-only clear
// [RULE_23] masked flag reads zero, no fault state
module dff_fault_flags
   import dff_pkg::*;
#(
   parameter int TEMP_CHECK_CYC = TEMP_CHECK_CYCLES,
   parameter int OSC_NOM_CYC    = OSC_NOM_CYCLES
)(
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire logic                angle_update,
   input  wire logic [ANGLE_W-1:0]  angle_value,
   input  wire logic [ANGLE_W-1:0]  upper_clamp_value,
   input  wire logic [ANGLE_W-1:0]  lower_clamp_value,
   input  wire logic [ANGLE_W-1:0]  pre_gain_result,
   input  wire logic [ANGLE_W-1:0]  angle_window_low,
   input  wire logic [ANGLE_W-1:0]  angle_window_high,
   input  wire logic [ANGLE_W:0]    gain_result_raw,
   input  wire logic                offset_overflow,
   input  wire logic                angle_window_check_enable,
   input  wire logic                gain_overflow_check_enable,
   input  wire logic                offset_overflow_check_enable,
   input  wire logic                filter_saturation,
   input  wire logic                channel_saturation,
   input  wire logic                linearization_overrange,
   input  wire logic                filter_subflag_mask,
   input  wire logic                channel_subflag_mask,
   input  wire logic                correction_subflag_mask,
   input  wire logic                linearization_subflag_mask,
   input  wire logic                saturation_global_mask,
   input  wire logic [3:0]          fault_filter_setting,
   input  wire logic                analog_check_fail,
   input  wire logic                temperature_out_of_range,
   input  wire logic                logic_check_fail,
   input  wire logic                radius_out_of_range,
   input  wire logic                undervoltage,
   input  wire logic                overvoltage,
   input  wire logic                eeprom_single_error,
   input  wire logic                eeprom_multi_error,
   input  wire logic                shadow_parity_error,
   input  wire logic                watchdog_osc,
   input  wire logic                analog_check_mask,
   input  wire logic                clamp_flag_mask,
   input  wire logic                temperature_flag_mask,
   input  wire logic                oscillator_flag_mask,
   input  wire logic                power_on_mask,
   input  wire logic                radius_mask,
   input  wire logic                eeprom_single_mask,
   input  wire logic                shadow_parity_mask,
   input  wire logic                reg_rd_en,
   input  wire logic [7:0]          reg_addr,
   input  wire logic                report_done,
   output logic [31:0]              rd_data_r,
   output logic                     rd_valid_r,
   output logic [FLAG_COUNT-1:0]    flag_word_r,
   output logic                     fault_state_r,
   output logic [ANGLE_W-1:0]       gain_result_r,
   output logic                     filter_sat_subflag_r,
   output logic                     channel_sat_subflag_r,
   output logic                     correction_sat_subflag_r,
   output logic                     linearization_sat_subflag_r
);
   localparam int OSC_LO     = OSC_NOM_CYC * (100 - OSC_TOL_PCT) / 100;
   localparam int OSC_HI     = OSC_NOM_CYC * (100 + OSC_TOL_PCT) / 100;
   localparam int OSC_CNT_W  = $clog2(OSC_HI + 2);
   localparam int TEMP_CNT_W = $clog2(TEMP_CHECK_CYC + 1);

   // elaboration check: refuse parameters the counters cannot serve
   if (TEMP_CHECK_CYC < 1 || OSC_NOM_CYC < 5)
   begin : g_bad_param
      $error("dff_fault_flags: parameter out of range");
   end

   // one-update step of a saturating filter counter
   function automatic logic [3:0] filt_step(input logic cond, input logic [3:0] cnt);
      filt_step = (cond && cnt != 4'hf) ? cnt + 4'h1 : (cond ? cnt : 4'h0);
   endfunction

   // sticky flag: set wins over clear; clear only when cause is gone
   function automatic logic sticky(input logic flag, input logic set, input logic active,
                                   input logic clr);
      sticky = set | (flag & ~(clr & ~active));
   endfunction

   logic                 wd_sync1_r, wd_sync2_r, wd_prev_r;
   logic [3:0]           clamp_cnt_r, clamp_cnt_nxt, sat_cnt_r, sat_cnt_nxt;
   logic                 clamp_act_r, clamp_act_nxt, sat_act_r, sat_act_nxt;
   logic [TEMP_CNT_W-1:0] temp_cnt_r, temp_cnt_nxt;
   logic                 temp_act_r, temp_act_nxt;
   logic                 first_upd_r, first_upd_nxt;
   logic [3:0]           osc_upd_r, osc_upd_nxt;
   logic [OSC_CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
   dff_osc_state_t       osc_st_r, osc_st_nxt;
   logic                 osc_fail;
   logic [FLAG_COUNT-1:0] flag_nxt, mask_vec, cond_vec, set_vec;
   logic [31:0]          rd_data_nxt;
   logic                 rd_valid_nxt, fault_nxt, clr, word_read, wd_rise;
   logic [ANGLE_W-1:0]   gain_nxt;
   logic                 filt_sf, chan_sf, cor_sf, lin_sf, sat_cond, clamp_cond;

   assign wd_rise   = wd_sync2_r & ~wd_prev_r;
   assign word_read = reg_rd_en && reg_addr == ADDR_FLAG_WORD;
   assign clr       = word_read | report_done;                            // see [RULE_02]

   // saturation sub-flags and gain wrap/saturate
   always_comb
   begin
      filt_sf  = filter_saturation & ~filter_subflag_mask;                 // see [RULE_13]
      chan_sf  = channel_saturation & ~channel_subflag_mask;               // see [RULE_14]
      cor_sf   = ~correction_subflag_mask &                                // see [RULE_15]
                 ((angle_window_check_enable &&
                   (pre_gain_result < angle_window_low ||
                    pre_gain_result > angle_window_high)) ||
                  (gain_overflow_check_enable && gain_result_raw[ANGLE_W]) ||
                  (offset_overflow_check_enable && offset_overflow));
      lin_sf   = linearization_overrange & ~linearization_subflag_mask;    // see [RULE_16]
      sat_cond = (filt_sf | chan_sf | cor_sf | lin_sf) & ~saturation_global_mask; // see [RULE_11]
      if (gain_overflow_check_enable && gain_result_raw[ANGLE_W])
      begin
         gain_nxt = {ANGLE_W{1'b1}};
      end
      else
      begin
         gain_nxt = gain_result_raw[ANGLE_W-1:0];                          // see [RULE_15]
      end
      clamp_cond = ~clamp_flag_mask &&                                     // see [RULE_06]
                   (angle_value >= upper_clamp_value || angle_value <= lower_clamp_value);
   end

   // per-update fault filters, temperature sampling, first-update tracking
   always_comb
   begin
      clamp_cnt_nxt = clamp_cnt_r;
      clamp_act_nxt = clamp_act_r;
      sat_cnt_nxt   = sat_cnt_r;
      sat_act_nxt   = sat_act_r;
      first_upd_nxt = first_upd_r | angle_update;                          // see [RULE_21]
      if (angle_update)
      begin
         clamp_cnt_nxt = filt_step(clamp_cond, clamp_cnt_r);               // see [RULE_07]
         clamp_act_nxt = clamp_cond && clamp_cnt_r >= fault_filter_setting;
         sat_cnt_nxt   = filt_step(sat_cond, sat_cnt_r);                   // see [RULE_18]
         sat_act_nxt   = sat_cond && sat_cnt_r >= fault_filter_setting;
      end
      temp_act_nxt = temp_act_r;
      temp_cnt_nxt = temp_cnt_r + 1'b1;
      if (temp_cnt_r == TEMP_CNT_W'(TEMP_CHECK_CYC - 1))                   // see [RULE_09]
      begin
         temp_cnt_nxt = '0;
         temp_act_nxt = temperature_out_of_range;                          // see [RULE_08]
      end
   end

   // oscillator comparison against the synchronised watchdog oscillator
   always_comb
   begin
      osc_st_nxt  = osc_st_r;
      osc_cnt_nxt = osc_cnt_r;
      osc_upd_nxt = osc_upd_r;
      osc_fail    = 1'b0;
      case (osc_st_r)
         DFF_OSC_IDLE:
         begin
            if (angle_update)
            begin
               osc_upd_nxt = osc_upd_r + 4'h1;
               if (osc_upd_r == OSC_START_UPDATES - 4'h1)                  // see [RULE_20]
               begin
                  osc_upd_nxt = 4'h0;
                  osc_st_nxt  = DFF_OSC_WAIT;
               end
            end
         end
         DFF_OSC_WAIT:
         begin
            // start at one so a full watchdog period counts as its own length
            osc_cnt_nxt = OSC_CNT_W'(1);
            if (wd_rise)
            begin
               osc_st_nxt = DFF_OSC_MEASURE;
            end
         end
         DFF_OSC_MEASURE:
         begin
            osc_cnt_nxt = osc_cnt_r + 1'b1;
            if (wd_rise || osc_cnt_r > OSC_CNT_W'(OSC_HI))
            begin
               osc_fail   = osc_cnt_r < OSC_CNT_W'(OSC_LO) ||              // see [RULE_19]
                            osc_cnt_r > OSC_CNT_W'(OSC_HI);
               osc_st_nxt = DFF_OSC_IDLE;
            end
         end
         default:
         begin
            osc_st_nxt = DFF_OSC_IDLE;
         end
      endcase
   end

   // flag word
   always_comb
   begin
      mask_vec = '0;
      mask_vec[BIT_ANALOG]     = analog_check_mask;                        // see [RULE_04]
      mask_vec[BIT_CLAMP]      = clamp_flag_mask;
      mask_vec[BIT_TEMP]       = temperature_flag_mask;                    // see [RULE_10]
      mask_vec[BIT_SAT]        = saturation_global_mask;                   // see [RULE_12]
      mask_vec[BIT_RADIUS]     = radius_mask;
      mask_vec[BIT_POWER_ON]   = power_on_mask;
      mask_vec[BIT_EE_SINGLE]  = eeprom_single_mask;
      mask_vec[BIT_SHADOW_PAR] = shadow_parity_mask;
      mask_vec[BIT_OSC]        = oscillator_flag_mask;                     // see [RULE_20]
      cond_vec = '0;
      cond_vec[BIT_ANALOG]     = analog_check_fail;                        // see [RULE_03]
      cond_vec[BIT_CLAMP]      = clamp_act_r;                              // see [RULE_05]
      cond_vec[BIT_TEMP]       = temp_act_r;
      cond_vec[BIT_SAT]        = sat_act_r;                                // see [RULE_17]
      cond_vec[BIT_LOGIC]      = logic_check_fail;
      cond_vec[BIT_RADIUS]     = radius_out_of_range;
      cond_vec[BIT_POWER_ON]   = ~first_upd_r;                             // see [RULE_21]
      cond_vec[BIT_EE_SINGLE]  = eeprom_single_error;
      cond_vec[BIT_UNDERVOLT]  = undervoltage;
      cond_vec[BIT_OVERVOLT]   = overvoltage;
      cond_vec[BIT_EE_MULTI]   = eeprom_multi_error;                       // see [RULE_22]
      cond_vec[BIT_SHADOW_PAR] = shadow_parity_error;
      cond_vec[BIT_OSC]        = osc_fail;
      set_vec = cond_vec & ~mask_vec;                                      // see [RULE_23]
      set_vec[BIT_POWER_ON] = 1'b0;
      for (int i = 0; i < FLAG_COUNT; i++)
      begin
         flag_nxt[i] = sticky(flag_word_r[i], set_vec[i], cond_vec[i], clr);
      end
      // critical flags ignore read/report clear; a mask still clears the maskable ones
      flag_nxt[BIT_EE_MULTI]   = flag_word_r[BIT_EE_MULTI] | set_vec[BIT_EE_MULTI];
      flag_nxt[BIT_SHADOW_PAR] = flag_word_r[BIT_SHADOW_PAR] | set_vec[BIT_SHADOW_PAR];
      flag_nxt[BIT_OSC]        = flag_word_r[BIT_OSC] | set_vec[BIT_OSC];  // see [RULE_19]
      flag_nxt = flag_nxt & ~mask_vec;                                     // see [RULE_23]
      fault_nxt = |(flag_nxt & ~(FLAG_COUNT'(1) << BIT_EE_SINGLE));        // see [RULE_03]
      rd_valid_nxt = reg_rd_en;
      rd_data_nxt  = '0;
      if (word_read)
      begin
         rd_data_nxt = {{(32 - FLAG_COUNT){1'b0}}, flag_word_r & ~mask_vec}; // see [RULE_01]
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         wd_sync1_r    <= 1'b0;
         wd_sync2_r    <= 1'b0;
         wd_prev_r     <= 1'b0;
         clamp_cnt_r   <= 4'h0;
         clamp_act_r   <= 1'b0;
         sat_cnt_r     <= 4'h0;
         sat_act_r     <= 1'b0;
         temp_cnt_r    <= '0;
         temp_act_r    <= 1'b0;
         first_upd_r   <= 1'b0;
         osc_upd_r     <= 4'h0;
         osc_cnt_r     <= '0;
         osc_st_r      <= DFF_OSC_IDLE;
         flag_word_r   <= FLAG_WORD_RESET[FLAG_COUNT-1:0];                 // see [RULE_21]
         fault_state_r <= 1'b0;
         rd_data_r     <= 32'h0000_0000;
         rd_valid_r    <= 1'b0;
         gain_result_r <= '0;
         filter_sat_subflag_r        <= 1'b0;
         channel_sat_subflag_r       <= 1'b0;
         correction_sat_subflag_r    <= 1'b0;
         linearization_sat_subflag_r <= 1'b0;
      end
      else
      begin
         wd_sync1_r    <= watchdog_osc;
         wd_sync2_r    <= wd_sync1_r;
         wd_prev_r     <= wd_sync2_r;
         clamp_cnt_r   <= clamp_cnt_nxt;
         clamp_act_r   <= clamp_act_nxt;
         sat_cnt_r     <= sat_cnt_nxt;
         sat_act_r     <= sat_act_nxt;
         temp_cnt_r    <= temp_cnt_nxt;
         temp_act_r    <= temp_act_nxt;
         first_upd_r   <= first_upd_nxt;
         osc_upd_r     <= osc_upd_nxt;
         osc_cnt_r     <= osc_cnt_nxt;
         osc_st_r      <= osc_st_nxt;
         flag_word_r   <= flag_nxt;
         fault_state_r <= fault_nxt;
         rd_data_r     <= rd_data_nxt;
         rd_valid_r    <= rd_valid_nxt;
         gain_result_r <= gain_nxt;
         filter_sat_subflag_r        <= filt_sf;
         channel_sat_subflag_r       <= chan_sf;
         correction_sat_subflag_r    <= cor_sf;
         linearization_sat_subflag_r <= lin_sf;
      end
   end
endmodule

// ### tb/dff_fault_flags_assertions.sv
// concurrent checks on the fault-flag unit ports
`timescale 1ns/1ps
module dff_chk
   import dff_pkg::*;
(
   input wire logic                  mclk,
   input wire logic                  reset,
   input wire logic                  reg_rd_en,
   input wire logic [7:0]            reg_addr,
   input wire logic                  rd_valid_r,
   input wire logic [31:0]           rd_data_r,
   input wire logic [FLAG_COUNT-1:0] flag_word_r,
   input wire logic                  eeprom_multi_error,
   input wire logic                  analog_check_mask,
   input wire logic                  clamp_flag_mask,
   input wire logic                  saturation_global_mask
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   rd_answer_a: assert property (reg_rd_en |=> rd_valid_r)
      else $error("read not answered");
   rd_word_a: assert property (reg_rd_en && reg_addr == ADDR_FLAG_WORD |=>
      rd_data_r == {19'h0, $past(flag_word_r)}) else $error("read word wrong");
   bad_addr_a: assert property (reg_rd_en && reg_addr != ADDR_FLAG_WORD |=>
      rd_data_r == 32'h0) else $error("unmapped read not zero");
   multi_set_a: assert property (
      eeprom_multi_error |=> flag_word_r[BIT_EE_MULTI])
      else $error("multi-bit flag not set");
   multi_hold_a: assert property (flag_word_r[BIT_EE_MULTI] |=>
      flag_word_r[BIT_EE_MULTI]) else $error("multi-bit flag cleared");
   analog_mask_a: assert property (
      analog_check_mask && $past(analog_check_mask) |-> !flag_word_r[BIT_ANALOG])
      else $error("masked analog flag set");
   clamp_mask_a: assert property (
      clamp_flag_mask && $past(clamp_flag_mask) |-> !flag_word_r[BIT_CLAMP])
      else $error("masked clamp flag set");
   saturation_global_mask_a: assert property (
      saturation_global_mask && $past(saturation_global_mask) |-> !flag_word_r[BIT_SAT])
      else $error("masked saturation flag set");
   cover property (reg_rd_en && reg_addr == ADDR_FLAG_WORD ##1 rd_valid_r);
   cover property (flag_word_r[BIT_EE_MULTI]);
   cover property (saturation_global_mask ##1 saturation_global_mask);
endmodule

// ### tb/test_dff_fault_flags.sv
// self-checking bench for the diagnostic fault-flag unit
`timescale 1ns/1ps
module test_dff_fault_flags
   import dff_pkg::*;
;
   localparam int TCYC = 20;
   logic mclk = 1'b0, reset = 1'b1, angle_update = 1'b0, report_done = 1'b0, reg_rd_en = 1'b0;
   logic analog_check_fail = 1'b0, temperature_out_of_range = 1'b0, eeprom_multi_error = 1'b0;
   logic analog_check_mask = 1'b0, clamp_flag_mask = 1'b0, temperature_flag_mask = 1'b0;
   logic saturation_global_mask = 1'b0, oscillator_flag_mask = 1'b0, power_on_mask = 1'b0;
   logic angle_window_check_enable = 1'b1, gain_overflow_check_enable = 1'b1;
   logic offset_overflow_check_enable = 1'b1;
   logic [7:0] reg_addr = ADDR_FLAG_WORD;
   logic [3:0] fault_filter_setting = 4'h0, sub_mask = 4'h0;
   logic [5:0] sat_src = 6'h0, misc = 6'h0, misc_mask = 6'h0;
   logic [ANGLE_W-1:0] angle_value = 16'h4000, upper_clamp_value = 16'h8000;
   logic [ANGLE_W-1:0] lower_clamp_value = 16'h1000, angle_window_low = 16'h0100;
   logic [ANGLE_W-1:0] angle_window_high = 16'he000;
   int bad_count = 0, n_compared = 0, wd_cnt = 0, wd_half = 5;
   int bits[6] = '{BIT_LOGIC, BIT_RADIUS, BIT_UNDERVOLT, BIT_OVERVOLT, BIT_EE_SINGLE,
      BIT_SHADOW_PAR};
   int sub_of[6] = '{0, 1, 2, 2, 2, 3};
   wire logic [ANGLE_W-1:0] pre_gain_result = sat_src[2] ? 16'hf000 : 16'h8000;
   wire logic [ANGLE_W:0] gain_result_raw = {sat_src[3], 16'h1234};
   wire logic filter_saturation = sat_src[0], channel_saturation = sat_src[1];
   wire logic offset_overflow = sat_src[4], linearization_overrange = sat_src[5];
   wire logic filter_subflag_mask = sub_mask[0], channel_subflag_mask = sub_mask[1];
   wire logic correction_subflag_mask = sub_mask[2], linearization_subflag_mask = sub_mask[3];
   wire logic logic_check_fail = misc[0], radius_out_of_range = misc[1], undervoltage = misc[2];
   wire logic overvoltage = misc[3], eeprom_single_error = misc[4], shadow_parity_error = misc[5];
   wire logic radius_mask = misc_mask[1], eeprom_single_mask = misc_mask[4];
   wire logic shadow_parity_mask = misc_mask[5];
   wire logic watchdog_osc = wd_cnt < wd_half;
   logic [31:0] rd_data_r;
   logic [FLAG_COUNT-1:0] flag_word_r;
   logic [ANGLE_W-1:0] gain_result_r;
   logic rd_valid_r, fault_state_r, filter_sat_subflag_r, channel_sat_subflag_r;
   logic correction_sat_subflag_r, linearization_sat_subflag_r;
   wire [3:0] sub_out = {linearization_sat_subflag_r, correction_sat_subflag_r,
      channel_sat_subflag_r, filter_sat_subflag_r};

   dff_fault_flags #(.TEMP_CHECK_CYC(TCYC), .OSC_NOM_CYC(10)) uut (.*);
   initial forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
   // slow watchdog oscillator, nominal period ten clocks
   always @(negedge mclk) wd_cnt <= (wd_cnt + 1) % (2 * wd_half);

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic fw(input int b, input logic e);
      check("flag bit", {31'h0, flag_word_r[b]}, {31'h0, e});
   endtask
   task automatic rd(input logic [31:0] exp);
      @(negedge mclk);
      reg_rd_en = 1'b1;
      @(negedge mclk);
      reg_rd_en = 1'b0;
      check("read valid", {31'h0, rd_valid_r}, 32'h1);
      check("read word", rd_data_r, exp);
   endtask
   task automatic upd;
      @(negedge mclk);
      angle_update = 1'b1;
      @(negedge mclk);
      angle_update = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic t_start;
      repeat (2) @(negedge mclk);
      check("fault state", {31'h0, fault_state_r}, 32'h1);
      rd(32'h40);
      rd(32'h40);
      upd();
      rd(32'h40);
      rd(32'h0);
      reg_addr = 8'h00;
      rd(32'h0);
      reg_addr = ADDR_FLAG_WORD;
      analog_check_fail = 1'b1;
      repeat (2) @(negedge mclk);
      fw(BIT_ANALOG, 1'b1);
      check("fault state", {31'h0, fault_state_r}, 32'h1);
      analog_check_fail = 1'b0;
      @(negedge mclk);
      report_done = 1'b1;
      @(negedge mclk);
      report_done = 1'b0;
      @(negedge mclk);
      fw(BIT_ANALOG, 1'b0);
      analog_check_mask = 1'b1;
      analog_check_fail = 1'b1;
      repeat (3) @(negedge mclk);
      fw(BIT_ANALOG, 1'b0);
      check("fault state", {31'h0, fault_state_r}, 32'h0);
      analog_check_fail = 1'b0;
      analog_check_mask = 1'b0;
   endtask
   task automatic t_clamp;
      fault_filter_setting = 4'h2;
      angle_value = 16'h9000;
      upd();
      upd();
      fw(BIT_CLAMP, 1'b0);
      upd();
      fw(BIT_CLAMP, 1'b1);
      angle_value = 16'h4000;
      upd();
      rd(32'h2);
      rd(32'h0);
      clamp_flag_mask = 1'b1;
      angle_value = 16'h1000;
      repeat (3) upd();
      fw(BIT_CLAMP, 1'b0);
      angle_value = 16'h4000;
      upd();
      rd(32'h0);
      clamp_flag_mask = 1'b0;
      fault_filter_setting = 4'h0;
   endtask
   task automatic t_temp;
      temperature_out_of_range = 1'b1;
      for (int n = 0; n < TCYC + 3 && flag_word_r[BIT_TEMP] !== 1'b1; n++)
         @(negedge mclk);
      fw(BIT_TEMP, 1'b1);
      check("fault state", {31'h0, fault_state_r}, 32'h1);
      temperature_out_of_range = 1'b0;
      repeat (TCYC + 3) @(negedge mclk);
      rd(32'h4);
      rd(32'h0);
      temperature_flag_mask = 1'b1;
      temperature_out_of_range = 1'b1;
      repeat (TCYC + 3) @(negedge mclk);
      fw(BIT_TEMP, 1'b0);
      check("fault state", {31'h0, fault_state_r}, 32'h0);
      temperature_out_of_range = 1'b0;
      repeat (TCYC + 3) @(negedge mclk);
      temperature_flag_mask = 1'b0;
      rd(32'h0);
   endtask
   task automatic t_sat;
      for (int i = 0; i < 6; i++)
      begin
         sat_src = 6'h1 << i;
         upd();
         check("sub flags", {28'h0, sub_out}, 32'h1 << sub_of[i]);
         fw(BIT_SAT, 1'b1);
         sub_mask = 4'h1 << sub_of[i];
         upd();
         check("masked sub flags", {28'h0, sub_out}, 32'h0);
         sat_src = 6'h0;
         sub_mask = 4'h0;
         upd();
         rd(32'h8);
         rd(32'h0);
      end
      sat_src = 6'h08;
      repeat (2) @(negedge mclk);
      check("gain clipped", {16'h0, gain_result_r}, 32'hffff);
      gain_overflow_check_enable = 1'b0;
      angle_window_check_enable = 1'b0;
      offset_overflow_check_enable = 1'b0;
      repeat (2) @(negedge mclk);
      check("gain wrapped", {16'h0, gain_result_r}, 32'h1234);
      fault_filter_setting = 4'h1;
      sat_src = 6'h01;
      upd();
      fw(BIT_SAT, 1'b0);
      upd();
      fw(BIT_SAT, 1'b1);
      sat_src = 6'h0;
      fault_filter_setting = 4'h0;
      upd();
      rd(32'h8);
      saturation_global_mask = 1'b1;
      sat_src = 6'h3f;
      repeat (2) upd();
      fw(BIT_SAT, 1'b0);
      sat_src = 6'h0;
      upd();
      rd(32'h0);
      saturation_global_mask = 1'b0;
   endtask
   task automatic t_misc;
      for (int i = 0; i < 6; i++)
      begin
         misc = 6'h1 << i;
         misc_mask = misc;
         repeat (2) @(negedge mclk);
         fw(bits[i], !(i inside {1, 4, 5}));
         misc_mask = 6'h0;
         repeat (2) @(negedge mclk);
         fw(bits[i], 1'b1);
         misc = 6'h0;
         rd(32'h1 << bits[i]);
         rd(i == 5 ? 32'h800 : 32'h0);
      end
   endtask
   task automatic t_osc;
      repeat (10) upd();
      fw(BIT_OSC, 1'b0);
      // slow watchdog is far off nominal until the final reset; the mask hides it first
      oscillator_flag_mask = 1'b1;
      wd_half = 15;
      repeat (10) upd();
      repeat (100) @(negedge mclk);
      fw(BIT_OSC, 1'b0);
      oscillator_flag_mask = 1'b0;
      repeat (10) upd();
      repeat (100) @(negedge mclk);
      rd(32'h1800);
      rd(32'h1800);
      eeprom_multi_error = 1'b1;
      @(negedge mclk);
      eeprom_multi_error = 1'b0;
      rd(32'h1c00);
      power_on_mask = 1'b1;
      reset = 1'b1;
      wd_half = 5;
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      repeat (2) @(negedge mclk);
      check("flag word", {19'h0, flag_word_r}, 32'h0);
   endtask

   initial
   begin
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      t_start();
      t_clamp();
      t_temp();
      t_sat();
      t_misc();
      t_osc();
      final_report();
   end
   initial
   begin
      repeat (5000) @(negedge mclk);
      bad_count++;
      final_report();
   end
endmodule
bind dff_fault_flags dff_chk chk (.*);
